/* File: shared/owm_defines.svh */
// Purpose: constants for the single-wire master configuration and status block
// Assumes: 40 MHz system clock, one clock domain
// Notes: field positions, reset values, pointer codes and timing counts
// Notes on behaviour
// - after power-up or device reset the configuration reads zero
// - configuration write accepted only when upper nibble inverts lower nibble
// - configuration reads return zero in the upper nibble
// - pullup, strong pullup and speed selections independent; pullup and speed persist
// - without active or strong pullup, rising edges are left to the resistor
// - with active pullup, drive high after threshold until on-time expires
// - no active pullup on presence pulse end or short recovery
// - strong pullup holds after slot edge until bus command, clear, or reset
// - external gate output low exactly while strong pullup conducts
// - strong pullup end clears its enable and leaves active pullup alone
// - speed cleared selects standard timing, slot within 65 us
// - speed cleared then bus reset returns everything to standard timing
// - busy flag is one for the whole bus command, zero after
// - presence flag set on presence sample, cleared otherwise or on short
// - bus commands and device reset move the read pointer to status
// - three readable registers chosen by a pointer set by last command
// - status read-only, bits change only in their defining commands
// - short sampled low sets short flag and forces presence flag zero
// - reads addressed at status sample the line into the level flag
// - device reset flag set on internal reset, cleared by configuration write
`ifndef OWM_DEFINES_SVH
`define OWM_DEFINES_SVH

// ==============================================
// configuration field positions
`define CFG_APU_BIT       0
`define CFG_SPU_BIT       2
`define CFG_ODS_BIT       3
`define CFG_RESET         8'h00
`define NIB_LO            3:0
`define NIB_HI            7:4
`define NIB_ZERO          4'h0

// ==============================================
// status field positions
`define ST_BUSY_BIT       0
`define ST_PRES_BIT       1
`define ST_SHORT_BIT      2
`define ST_LEVEL_BIT      3
`define ST_RST_BIT        4
`define ST_SBR_BIT        5
`define ST_TSB_BIT        6
`define ST_DIR_BIT        7

// ==============================================
// read pointer codes
`define PTR_STATUS        8'hf0
`define PTR_DATA          8'he1
`define PTR_CONFIG        8'hc3

// ==============================================
// timing: active pullup on-time and slot bound
`define CLK_MHZ           40
`define APU_ON_NS         2500
`define APU_ON_CYC        ((`APU_ON_NS * `CLK_MHZ) / 1000)
`define SLOT_STD_US       65
`define SLOT_STD_CYC      (`SLOT_STD_US * `CLK_MHZ)
`define TMR_W             12

`endif

/* File: shared/owm_pkg.sv */
// Purpose: types for the single-wire master configuration and status block
// Assumes: constants come from owm_defines.svh
// Notes: no imports are used anywhere; names are written with the package
package owm_pkg;

	// ==============================================
	// stored configuration selections
	typedef struct packed {
		logic overdrive_select;
		logic strong_pullup_enable;
		logic active_pullup_enable;
	} cfg_t;

	// ==============================================
	// events from the bus engine
	typedef struct packed {
		logic cmd_start;      // bus-generating command begins
		logic cmd_done;       // bus command completed
		logic is_bus_reset;   // the command starting is a bus reset
		logic presence_smp;   // presence sample point pulse
		logic short_smp;      // short sample point pulse
		logic bit1_smp;       // first bit sample pulse
		logic bit2_smp;       // second bit sample pulse
		logic dir_smp;        // direction result pulse
	} eng_ev_t;

	typedef enum logic [1:0] {
		PTR_SEL_STATUS,
		PTR_SEL_DATA,
		PTR_SEL_CONFIG
	} ptr_sel_t;

	typedef enum logic [1:0] {
		PU_IDLE,
		PU_ACTIVE,
		PU_STRONG
	} pu_state_t;

endpackage : owm_pkg

/* File: core/owm_cfg_check.sv */
// Purpose: configuration write check and stored selections
// Assumes: write pulse one cycle, data byte stable with it
// Notes: strong pullup clear request comes from the pullup sequencer
`timescale 1ns/1ps
`include "owm_defines.svh"
module owm_cfg_check (
	input  wire logic          sys_clk_i,
	input  wire logic          arst_n_i,
	input  wire logic          dev_rst_i,
	input  wire logic          wr_i,
	input  wire logic [7:0]    wdata_i,
	input  wire logic          spu_end_i,
	output owm_pkg::cfg_t      cfg_o,
	output logic               accepted_o
);
	// guard check: upper nibble must be the inverse of the lower
	function automatic logic nib_ok(input logic [7:0] b);
		nib_ok = (b[`NIB_HI] == ~b[`NIB_LO]);
	endfunction : nib_ok

	logic good;
	assign good = wr_i && nib_ok(wdata_i);

	// ==============================================
	// selections; a failed write keeps everything as it was
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_o <= '0;
		end else if (dev_rst_i) begin
			cfg_o <= '0;
		end else if (good) begin
			cfg_o.active_pullup_enable <= wdata_i[`CFG_APU_BIT];
			cfg_o.strong_pullup_enable <= wdata_i[`CFG_SPU_BIT];
			cfg_o.overdrive_select     <= wdata_i[`CFG_ODS_BIT];
		end else if (spu_end_i) begin
			cfg_o.strong_pullup_enable <= 1'b0;
		end
	end

	// accepted pulse for the reset flag clear
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			accepted_o <= 1'b0;
		end else begin
			accepted_o <= good;
		end
	end

	a_reject_keeps: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(wr_i && !good && !dev_rst_i && !spu_end_i) |=> $stable(cfg_o))
		else $error("rejected write changed configuration");
	a_good_loads: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(good && !dev_rst_i) |=> cfg_o.overdrive_select == $past(wdata_i[`CFG_ODS_BIT]))
		else $error("accepted write not stored");
endmodule : owm_cfg_check

/* File: core/owm_pullup_seq.sv */
// Purpose: active and strong pullup sequencing and external gate
// Assumes: rise_i pulses when a rising line crosses the input threshold
// Notes: on-time is a fixed count; strong pullup holds until released
`timescale 1ns/1ps
`include "owm_defines.svh"
module owm_pullup_seq (
	input  wire logic          sys_clk_i,
	input  wire logic          arst_n_i,
	input  wire logic          dev_rst_i,
	input  wire logic          rise_i,
	input  wire logic          no_apu_edge_i,
	input  wire logic          apu_en_i,
	input  wire logic          spu_en_i,
	input  wire logic          release_i,
	output logic               pullup_drive_o,
	output logic               ext_pullup_gate_n_o,
	output logic               spu_end_o
);
	owm_pkg::pu_state_t         st_q;
	logic [`TMR_W-1:0]          tmr_q;
	logic                       strong_go;
	logic                       apu_go;

	// presence end and short recovery never get the transistor
	assign strong_go = rise_i && !no_apu_edge_i && spu_en_i;
	assign apu_go    = rise_i && !no_apu_edge_i && apu_en_i && !spu_en_i;

	// ==============================================
	// pullup state and on-time counter
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q  <= owm_pkg::PU_IDLE;
			tmr_q <= '0;
		end else if (dev_rst_i) begin
			st_q  <= owm_pkg::PU_IDLE;
			tmr_q <= '0;
		end else begin
			case (st_q)
				owm_pkg::PU_IDLE: begin
					if (strong_go) begin
						st_q <= owm_pkg::PU_STRONG;
					end else if (apu_go) begin
						st_q  <= owm_pkg::PU_ACTIVE;
						tmr_q <= `TMR_W'(`APU_ON_CYC - 1);
					end
				end
				owm_pkg::PU_ACTIVE: begin
					if (tmr_q == '0) begin
						st_q <= owm_pkg::PU_IDLE;
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				owm_pkg::PU_STRONG: begin
					if (release_i || !spu_en_i) begin
						st_q <= owm_pkg::PU_IDLE;
					end
				end
				default: st_q <= owm_pkg::PU_IDLE;
			endcase
		end
	end

	// outputs registered; gate low exactly with strong state
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pullup_drive_o      <= 1'b0;
			ext_pullup_gate_n_o <= 1'b1;
			spu_end_o           <= 1'b0;
		end else begin
			pullup_drive_o      <= (st_q != owm_pkg::PU_IDLE);
			ext_pullup_gate_n_o <= (st_q != owm_pkg::PU_STRONG);
			spu_end_o           <= (st_q == owm_pkg::PU_STRONG) && release_i;
		end
	end

	a_gate_tracks: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		##1 (ext_pullup_gate_n_o == ($past(st_q) != owm_pkg::PU_STRONG)))
		else $error("gate does not follow strong pullup");
	a_no_apu_off: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(st_q == owm_pkg::PU_IDLE && rise_i && !apu_en_i && !spu_en_i)
		|=> st_q == owm_pkg::PU_IDLE)
		else $error("pullup driven with active pullup off");
	a_apu_ontime: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(st_q == owm_pkg::PU_IDLE && apu_go && !dev_rst_i)
		|=> (st_q == owm_pkg::PU_ACTIVE) [*8])
		else $error("active pullup ended early");
	a_skip_edge: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(st_q == owm_pkg::PU_IDLE && no_apu_edge_i) |=> st_q == owm_pkg::PU_IDLE)
		else $error("pullup on presence or short edge");
	c_strong: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		st_q == owm_pkg::PU_STRONG ##1 st_q == owm_pkg::PU_IDLE);
	c_active: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		st_q == owm_pkg::PU_ACTIVE);
endmodule : owm_pullup_seq

/* File: core/owm_cfg_status.sv */
// Purpose: configuration, status and read pointer of the single-wire master
// Assumes: command layer and slot engine deliver one-cycle event pulses
// Notes: read data byte comes from the engine; this block selects it
`timescale 1ns/1ps
`include "owm_defines.svh"
module owm_cfg_status (
	input  wire logic            sys_clk_i,
	input  wire logic            arst_n_i,
	input  wire logic            dev_rst_cmd_i,
	input  wire logic            cfg_wr_i,
	input  wire logic [7:0]      cfg_wdata_i,
	input  wire logic            set_ptr_i,
	input  wire logic [7:0]      ptr_code_i,
	input  wire logic            read_addr_i,
	input  wire owm_pkg::eng_ev_t eng_ev_i,
	input  wire logic            line_i,
	input  wire logic            rise_i,
	input  wire logic            no_apu_edge_i,
	input  wire logic [7:0]      read_data_i,
	output logic [7:0]           rd_byte_o,
	output logic                 ptr_ack_o,
	output logic                 overdrive_select_o,
	output logic                 pullup_drive_o,
	output logic                 ext_pullup_gate_n_o
);
	owm_pkg::cfg_t       cfg;
	owm_pkg::ptr_sel_t   ptr_q;
	logic                cfg_ok;
	logic                spu_end;
	logic                busy_q;
	logic                pres_q;
	logic                short_q;
	logic                level_q;
	logic                rst_q;
	logic                sbr_q;
	logic                tsb_q;
	logic                dir_q;
	logic                in_reset_q;
	logic [7:0]          status;
	logic [7:0]          cfg_rd;

	// ==============================================
	// configuration store
	owm_cfg_check u_cfg (
		.sys_clk_i  (sys_clk_i),
		.arst_n_i   (arst_n_i),
		.dev_rst_i  (dev_rst_cmd_i),
		.wr_i       (cfg_wr_i),
		.wdata_i    (cfg_wdata_i),
		.spu_end_i  (spu_end),
		.cfg_o      (cfg),
		.accepted_o (cfg_ok)
	);

	// ==============================================
	// pullup sequencing; any new bus command releases strong pullup
	owm_pullup_seq u_pu (
		.sys_clk_i           (sys_clk_i),
		.arst_n_i            (arst_n_i),
		.dev_rst_i           (dev_rst_cmd_i),
		.rise_i              (rise_i),
		.no_apu_edge_i       (no_apu_edge_i),
		.apu_en_i            (cfg.active_pullup_enable),
		.spu_en_i            (cfg.strong_pullup_enable),
		.release_i           (eng_ev_i.cmd_start),
		.pullup_drive_o      (pullup_drive_o),
		.ext_pullup_gate_n_o (ext_pullup_gate_n_o),
		.spu_end_o           (spu_end)
	);

	// ==============================================
	// speed select straight from flop; reset takes it back to standard
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			overdrive_select_o <= 1'b0;
		end else if (dev_rst_cmd_i) begin
			overdrive_select_o <= 1'b0;
		end else begin
			// engine reads this at each command start, so a bus reset after a
			// clearing write already runs at standard speed
			overdrive_select_o <= cfg.overdrive_select;
		end
	end

	// ==============================================
	// busy flag: set on start, cleared on completion
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_q <= 1'b0;
		end else if (dev_rst_cmd_i) begin
			busy_q <= 1'b0;
		end else if (eng_ev_i.cmd_start) begin
			busy_q <= 1'b1;
		end else if (eng_ev_i.cmd_done) begin
			busy_q <= 1'b0;
		end
	end

	// ==============================================
	// presence and short; only a bus reset or a device reset touches these
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			in_reset_q <= 1'b0;
		end else if (dev_rst_cmd_i) begin
			in_reset_q <= 1'b0;
		end else if (eng_ev_i.cmd_start) begin
			// a start that meets the previous completion must still open its window
			in_reset_q <= eng_ev_i.is_bus_reset;
		end else if (eng_ev_i.cmd_done) begin
			in_reset_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pres_q  <= 1'b0;
			short_q <= 1'b0;
		end else if (dev_rst_cmd_i) begin
			pres_q  <= 1'b0;
			short_q <= 1'b0;
		end else if (in_reset_q) begin
			if (eng_ev_i.short_smp) begin
				short_q <= !line_i;
				if (!line_i) begin
					pres_q <= 1'b0;
				end
			end else if (eng_ev_i.presence_smp && !short_q) begin
				pres_q <= !line_i;
			end
		end
	end

	// ==============================================
	// bit results and direction, updated by sample pulses and cleared by device reset
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sbr_q <= 1'b0;
			tsb_q <= 1'b0;
			dir_q <= 1'b0;
		end else if (dev_rst_cmd_i) begin
			sbr_q <= 1'b0;
			tsb_q <= 1'b0;
			dir_q <= 1'b0;
		end else begin
			if (eng_ev_i.bit1_smp) begin
				sbr_q <= line_i;
			end
			if (eng_ev_i.bit2_smp) begin
				tsb_q <= line_i;
			end
			if (eng_ev_i.dir_smp) begin
				dir_q <= line_i;
			end
		end
	end

	// ==============================================
	// line level sampled at read addressing with pointer at status
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			level_q <= 1'b0;
		end else if (read_addr_i && ptr_q == owm_pkg::PTR_SEL_STATUS) begin
			level_q <= line_i;
		end
	end

	// ==============================================
	// device reset flag; the set wins over a same-cycle clear
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_q <= 1'b1;
		end else if (dev_rst_cmd_i) begin
			rst_q <= 1'b1;
		end else if (cfg_ok) begin
			rst_q <= 1'b0;
		end
	end

	// ==============================================
	// read pointer: last executed command decides
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ptr_q     <= owm_pkg::PTR_SEL_STATUS;
			ptr_ack_o <= 1'b0;
		end else begin
			ptr_ack_o <= 1'b0;
			if (dev_rst_cmd_i || eng_ev_i.cmd_start) begin
				ptr_q <= owm_pkg::PTR_SEL_STATUS;
			end else if (cfg_wr_i) begin
				ptr_q <= owm_pkg::PTR_SEL_CONFIG;
			end else if (set_ptr_i) begin
				// invalid codes are not acknowledged and leave the pointer
				case (ptr_code_i)
					`PTR_STATUS: begin
						ptr_q     <= owm_pkg::PTR_SEL_STATUS;
						ptr_ack_o <= 1'b1;
					end
					`PTR_DATA: begin
						ptr_q     <= owm_pkg::PTR_SEL_DATA;
						ptr_ack_o <= 1'b1;
					end
					`PTR_CONFIG: begin
						ptr_q     <= owm_pkg::PTR_SEL_CONFIG;
						ptr_ack_o <= 1'b1;
					end
					default: ptr_q <= ptr_q;
				endcase
			end
		end
	end

	// ==============================================
	// status assembly and readback; status has no write path at all
	always_comb begin
		status                = 8'h00;
		status[`ST_BUSY_BIT]  = busy_q;
		status[`ST_PRES_BIT]  = pres_q;
		status[`ST_SHORT_BIT] = short_q;
		status[`ST_LEVEL_BIT] = level_q;
		status[`ST_RST_BIT]   = rst_q;
		status[`ST_SBR_BIT]   = sbr_q;
		status[`ST_TSB_BIT]   = tsb_q;
		status[`ST_DIR_BIT]   = dir_q;
		cfg_rd                = 8'h00;
		cfg_rd[`NIB_HI]       = `NIB_ZERO;
		cfg_rd[`CFG_APU_BIT]  = cfg.active_pullup_enable;
		cfg_rd[`CFG_SPU_BIT]  = cfg.strong_pullup_enable;
		cfg_rd[`CFG_ODS_BIT]  = cfg.overdrive_select;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_byte_o <= 8'h00;
		end else begin
			case (ptr_q)
				owm_pkg::PTR_SEL_STATUS: rd_byte_o <= status;
				owm_pkg::PTR_SEL_DATA:   rd_byte_o <= read_data_i;
				owm_pkg::PTR_SEL_CONFIG: rd_byte_o <= cfg_rd;
				default:                 rd_byte_o <= 8'h00;
			endcase
		end
	end

	// ==============================================
	// checks
	a_cfg_reset_zero: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		dev_rst_cmd_i |=> (cfg == '0) ##1 !overdrive_select_o)
		else $error("configuration not cleared by reset");
	a_upper_nibble: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		$past(ptr_q) == owm_pkg::PTR_SEL_CONFIG |-> rd_byte_o[`NIB_HI] == `NIB_ZERO)
		else $error("upper nibble not zero");
	a_busy_span: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(eng_ev_i.cmd_start && !dev_rst_cmd_i) |=> busy_q)
		else $error("busy not held during command");
	a_ptr_status: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(dev_rst_cmd_i || eng_ev_i.cmd_start) |=> ptr_q == owm_pkg::PTR_SEL_STATUS)
		else $error("pointer not moved to status");
	a_short_kills: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		short_q |-> !pres_q)
		else $error("presence set with short");
	a_rst_clear: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(cfg_ok && !dev_rst_cmd_i) |=> !rst_q)
		else $error("reset flag not cleared by configuration write");
	c_presence: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		$rose(pres_q));
	c_odrive: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		$rose(overdrive_select_o));
endmodule : owm_cfg_status

/* File: tb/host_model.sv */
// Purpose: host-side model issuing command pulses to the block
// Assumes: serial host framing already decoded into one-cycle requests
// Notes: every request launches at a falling edge and lasts one cycle
`timescale 1ns/1ps
module host_model (
	input  wire logic       sys_clk_i,
	input  wire logic       ptr_ack_i,
	output logic            dev_rst_o,
	output logic            cfg_wr_o,
	output logic [7:0]      cfg_wdata_o,
	output logic            set_ptr_o,
	output logic [7:0]      ptr_code_o,
	output logic            read_addr_o
);
	// ==========================================
	// request state
	logic ack_seen;

	// idle at time zero
	initial begin
		{dev_rst_o, cfg_wr_o, set_ptr_o, read_addr_o} = 4'h0;
		cfg_wdata_o = 8'h00;
		ptr_code_o = 8'h00;
		ack_seen = 1'b0;
	end

	// kind 0 reset, 1 config write, 2 pointer, 3 read address
	// released data shows the inverse so a stale byte is never reused
	task automatic issue(input logic [1:0] kind, input logic [7:0] val);
		@(negedge sys_clk_i);
		cfg_wdata_o = val;
		ptr_code_o = val;
		{dev_rst_o, cfg_wr_o, set_ptr_o, read_addr_o} = 4'h8 >> kind;
		@(negedge sys_clk_i);
		ack_seen = ptr_ack_i;
		{dev_rst_o, cfg_wr_o, set_ptr_o, read_addr_o} = 4'h0;
		cfg_wdata_o = ~val;
		ptr_code_o = ~val;
		@(negedge sys_clk_i);
	endtask : issue
	// host picks active pullup, sets strong pullup just before the powered
	// command and never leaves it on across a bus reset
endmodule : host_model

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the configuration and status block
// Assumes: 40 MHz clock, engine events driven as one-cycle pulses
// Notes: inputs change on falling edges; results read at falling edges
`timescale 1ns/1ps
module tb_top;
	// ==========================================
	// signals
	logic             clk, arst_n, dev_rst, cfg_wr, set_ptr, read_addr;
	logic             line, rise, no_apu, ack, ods, pu_drv, gate_n;
	logic [7:0]       wdata, pcode, rd_byte;
	logic [3:0]       lo;
	owm_pkg::eng_ev_t ev;
	int               fails, check_count, n;

	// ==========================================
	// instances
	owm_cfg_status owm_cfg_status_inst (.sys_clk_i(clk), .arst_n_i(arst_n),
		.dev_rst_cmd_i(dev_rst), .cfg_wr_i(cfg_wr), .cfg_wdata_i(wdata),
		.set_ptr_i(set_ptr), .ptr_code_i(pcode), .read_addr_i(read_addr),
		.eng_ev_i(ev), .line_i(line), .rise_i(rise), .no_apu_edge_i(no_apu),
		.read_data_i(8'h5a), .rd_byte_o(rd_byte), .ptr_ack_o(ack),
		.overdrive_select_o(ods), .pullup_drive_o(pu_drv),
		.ext_pullup_gate_n_o(gate_n));
	host_model host_model_inst (.sys_clk_i(clk), .ptr_ack_i(ack),
		.dev_rst_o(dev_rst), .cfg_wr_o(cfg_wr), .cfg_wdata_o(wdata),
		.set_ptr_o(set_ptr), .ptr_code_o(pcode), .read_addr_o(read_addr));

	// ==========================================
	// clock and watchdog; run needs well under 8000 cycles
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#200000;
		fails++;
		$display("watchdog expired");
		report_and_stop();
	end

	// ==========================================
	// compare and drive tasks
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp1
	task automatic hm(input logic [1:0] kind, input logic [7:0] val);
		host_model_inst.issue(kind, val);
	endtask : hm
	// point at a register and compare the byte it shows
	task automatic rd(input logic [7:0] code, input logic [7:0] exp);
		hm(2'd2, code);
		cmp8(rd_byte, exp);
	endtask : rd
	task automatic engine(input logic [7:0] b, input logic ln);
		@(negedge clk);
		ev = b;
		line = ln;
		@(negedge clk);
		ev = '0;
		@(negedge clk);
	endtask : engine
	// rising edge over threshold, then count pullup cycles in a window
	task automatic rise_count(input logic na);
		@(negedge clk);
		rise = 1'b1;
		no_apu = na;
		@(negedge clk);
		rise = 1'b0;
		n = 0;
		repeat (200) begin
			@(negedge clk);
			if (pu_drv === 1'b1) n++;
		end
	endtask : rise_count
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// ==========================================
	// test sequence
	initial begin
		fails = 0;
		check_count = 0;
		ev = '0;
		{line, rise, no_apu} = 3'b100;
		arst_n = 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk) arst_n = 1'b1;
		@(negedge clk);
		cmp8(rd_byte, 8'h10);
		cmp1(gate_n, 1'b1);
		rd(8'hc3, 8'h00);
		cmp1(host_model_inst.ack_seen, 1'b1);
		hm(2'd2, 8'h55);
		cmp1(host_model_inst.ack_seen, 1'b0);
		cmp8(rd_byte, 8'h00);
		rd(8'he1, 8'h5a);
		$display("test reset and pointer done");
		// every combination of the three selections, reserved bit kept 0
		for (int i = 0; i < 8; i++) begin
			lo = {i[2], i[1], 1'b0, i[0]};
			hm(2'd1, {~lo, lo});
			cmp8(rd_byte, {4'h0, lo});
			cmp1(ods, lo[3]);
		end
		hm(2'd1, 8'h19);
		cmp8(rd_byte, 8'h0d);
		cmp1(ods, 1'b1);
		rd(8'hf0, 8'h00);
		hm(2'd1, 8'hf0);
		cmp1(ods, 1'b0);
		$display("test configuration done");
		rd(8'hc3, 8'h00);
		engine(8'ha0, 1'b1);
		cmp8(rd_byte, 8'h01);
		engine(8'h10, 1'b0);
		cmp8(rd_byte, 8'h03);
		engine(8'h40, 1'b1);
		cmp8(rd_byte, 8'h02);
		cmp1(ods, 1'b0);
		engine(8'ha0, 1'b1);
		engine(8'h08, 1'b0);
		cmp8(rd_byte, 8'h05);
		engine(8'h10, 1'b0);
		cmp8(rd_byte, 8'h05);
		engine(8'h40, 1'b1);
		hm(2'd3, 8'h00);
		cmp8(rd_byte, 8'h0c);
		@(negedge clk) line = 1'b0;
		hm(2'd3, 8'h00);
		cmp8(rd_byte, 8'h04);
		@(negedge clk) line = 1'b1;
		$display("test bus reset done");
		hm(2'd1, 8'he1);
		rise_count(1'b0);
		cmp1(n >= 99 && n <= 101, 1'b1);
		cmp1(gate_n, 1'b1);
		rise_count(1'b1);
		cmp8(n[7:0], 8'h00);
		hm(2'd1, 8'hf0);
		rise_count(1'b0);
		cmp8(n[7:0], 8'h00);
		$display("test active pullup done");
		hm(2'd1, 8'ha5);
		rise_count(1'b0);
		cmp1(gate_n, 1'b0);
		cmp1(pu_drv, 1'b1);
		engine(8'h80, 1'b1);
		@(negedge clk);
		cmp1(gate_n, 1'b1);
		engine(8'h40, 1'b1);
		rd(8'hc3, 8'h01);
		hm(2'd1, 8'ha5);
		repeat (3) @(negedge clk);
		rise_count(1'b0);
		cmp1(gate_n, 1'b0);
		hm(2'd1, 8'he1);
		repeat (2) @(negedge clk);
		cmp1(gate_n, 1'b1);
		$display("test strong pullup done");
		hm(2'd1, 8'h69);
		cmp1(ods, 1'b1);
		hm(2'd0, 8'h00);
		cmp8(rd_byte, 8'h10);
		cmp1(ods, 1'b0);
		rd(8'hc3, 8'h00);
		$display("test device reset done");
		report_and_stop();
	end
endmodule : tb_top
